/* File: design/pkei_pkg.sv */
// power key event and interrupt package: register map, field positions,
// reset values, timing constants, the port carriers and the state carrier of the top module.
// assumes one 125 MHz clock and a plain byte-wide register port.
package pkei_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_KEY_STATUS = 8'h24;
    localparam logic [7:0] ADDR_KEY_MASK = 8'h25;
    localparam logic [7:0] ADDR_KEY_SENSE = 8'h26;
    localparam logic [7:0] ADDR_MISC_STATUS = 8'h28;
    localparam logic [7:0] ADDR_MISC_MASK = 8'h29;

    // ==========================================================
    // field positions and widths
    localparam int KEY_BITS = 6;
    localparam int MISC_BITS = 3;
    localparam int HOLD_STAGES = 5;
    localparam int BIT_KEY_PUSH = 0;
    localparam int BIT_HOLD_FIRST = 1;
    localparam int BIT_WAKE_DONE = 0;
    localparam int BIT_SLEEP_DONE = 1;
    localparam int BIT_POWER_BUTTON = 2;

    // ==========================================================
    // values after reset
    localparam logic [KEY_BITS-1:0] KEY_STATUS_RESET = 6'h00;
    localparam logic [KEY_BITS-1:0] KEY_MASK_RESET = 6'h3F;
    localparam logic [MISC_BITS-1:0] MISC_STATUS_RESET = 3'h0;
    localparam logic [MISC_BITS-1:0] MISC_MASK_RESET = 3'h7;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // timing: one reference tick per millisecond
    localparam int CLK_PERIOD_NS = 8;
    localparam int REF_TICK_NS = 1000000;
    localparam int REF_TICK_CYCLES = REF_TICK_NS / CLK_PERIOD_NS;
    localparam int HOLD_W = 14;
    localparam logic [HOLD_W-1:0] HOLD_LIMIT_MS [0:HOLD_STAGES-1] =
        '{14'h03E8, 14'h07D0, 14'h0BB8, 14'h0FA0, 14'h1F40};
    localparam logic [HOLD_W-1:0] HOLD_SATURATE = 14'h1F41;
    localparam int DEB_W = 8;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pkei_reg_req_t;

    typedef struct packed {
        logic wake_done;
        logic sleep_done;
        logic power_button;
    } pkei_misc_ev_t;

    typedef struct packed {
        logic [KEY_BITS-1:0] key_status;
        logic [KEY_BITS-1:0] key_mask;
        logic [MISC_BITS-1:0] misc_status;
        logic [MISC_BITS-1:0] misc_mask;
        logic [HOLD_STAGES-1:0] hold_sense;
        logic push_prev;
        logic [HOLD_W-1:0] hold_count;
        logic [7:0] rdata;
        logic irq_n;
    } pkei_state_t;

endpackage : pkei_pkg

/* File: design/pkei_ref_tick.sv */
// reference tick generator: one-cycle pulse every TICK_CYCLES clocks.
// assumes ce freezes the count.
`timescale 1ns/1ps
module pkei_ref_tick #(
    parameter int TICK_CYCLES = pkei_pkg::REF_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    output logic tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic tick;
    } pkei_tick_state_t;

    pkei_tick_state_t st;
    pkei_tick_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.count == LAST) begin
            next_st.count = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.count = st.count + CW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : pkei_ref_tick

/* File: design/pkei_debounce.sv */
// key debouncer with separate programmable press and release times.
// assumes key_n is synchronous and low while pressed; times in ticks.
`timescale 1ns/1ps
module pkei_debounce #(
    parameter int DW = pkei_pkg::DEB_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    input wire logic key_n,
    input wire logic [DW-1:0] fall_time,
    input wire logic [DW-1:0] rise_time,
    output logic pressed
);
    typedef struct packed {
        logic pressed;
        logic [DW-1:0] count;
    } pkei_deb_state_t;

    pkei_deb_state_t st;
    pkei_deb_state_t next_st;
    logic [DW-1:0] limit;

    always_comb begin
        next_st = st;
        limit = st.pressed ? rise_time : fall_time;
        if (key_n == st.pressed) begin
            // raw level disagrees with the debounced one: time it
            if (tick) begin
                if (st.count >= limit) begin
                    next_st.pressed = ~st.pressed;
                    next_st.count = '0;
                end else begin
                    next_st.count = st.count + DW'(1);
                end
            end
        end else begin
            next_st.count = '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign pressed = st.pressed;
endmodule : pkei_debounce

/* File: design/pkei_top.sv */
// power key event and interrupt block: debounced key, hold timers,
// sticky status, masks, sense and the active-low interrupt output.
// assumes a synchronous register port with one-cycle rd/wr strobes.
`timescale 1ns/1ps

module pkei_top #(
    parameter int TICK_CYCLES = pkei_pkg::REF_TICK_CYCLES,
    parameter int DW = pkei_pkg::DEB_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic power_key_n,
    input wire logic [DW-1:0] fall_debounce_ms,
    input wire logic [DW-1:0] rise_debounce_ms,
    input wire pkei_pkg::pkei_misc_ev_t misc_ev,
    input wire pkei_pkg::pkei_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic irq_out_n
);

    // ==========================================================
    // timing base and debouncer
    logic tick;
    logic key_push_sense;

    pkei_ref_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .tick(tick)
    );

    pkei_debounce #(
        .DW(DW)
    ) u_debounce (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .key_n(power_key_n),
        .fall_time(fall_debounce_ms),
        .rise_time(rise_debounce_ms),
        .pressed(key_push_sense)
    );

    // ==========================================================
    // state
    pkei_pkg::pkei_state_t st;
    pkei_pkg::pkei_state_t next_st;

    // per-cycle intermediate terms
    logic [pkei_pkg::KEY_BITS-1:0] key_set;
    logic [pkei_pkg::KEY_BITS-1:0] key_clr;
    logic [pkei_pkg::MISC_BITS-1:0] misc_set;
    logic [pkei_pkg::MISC_BITS-1:0] misc_clr;
    logic [pkei_pkg::HOLD_STAGES-1:0] hold_now;
    logic [7:0] key_sense_word;
    logic rd_key;
    logic rd_misc;
    logic wr_key;
    logic wr_misc;

    // ==========================================================
    // register decode
    always_comb begin
        rd_key = reg_req.rd && (reg_req.addr == pkei_pkg::ADDR_KEY_STATUS);
        rd_misc = reg_req.rd && (reg_req.addr == pkei_pkg::ADDR_MISC_STATUS);
        wr_key = reg_req.wr && (reg_req.addr == pkei_pkg::ADDR_KEY_STATUS);
        wr_misc = reg_req.wr && (reg_req.addr == pkei_pkg::ADDR_MISC_STATUS);
    end

    // ==========================================================
    // hold thresholds
    always_comb begin
        for (int i = 0; i < pkei_pkg::HOLD_STAGES; i++) begin
            hold_now[i] = key_push_sense &&
                (st.hold_count > pkei_pkg::HOLD_LIMIT_MS[i]);
        end
    end

    // ==========================================================
    // event sources
    always_comb begin
        key_set = '0;
        // any edge of the debounced level is one push event
        key_set[pkei_pkg::BIT_KEY_PUSH] = key_push_sense ^ st.push_prev;
        key_set[pkei_pkg::BIT_HOLD_FIRST +: pkei_pkg::HOLD_STAGES] =
            hold_now & ~st.hold_sense;
        misc_set = '0;
        misc_set[pkei_pkg::BIT_WAKE_DONE] = misc_ev.wake_done;
        misc_set[pkei_pkg::BIT_SLEEP_DONE] = misc_ev.sleep_done;
        misc_set[pkei_pkg::BIT_POWER_BUTTON] = misc_ev.power_button;
    end

    // ==========================================================
    // clear sources: a status read clears what it returns
    always_comb begin
        key_clr = '0;
        misc_clr = '0;
        if (rd_key) begin
            key_clr = st.key_status;
        end
        if (wr_key) begin
            key_clr = key_clr | reg_req.wdata[pkei_pkg::KEY_BITS-1:0];
        end
        if (rd_misc) begin
            misc_clr = st.misc_status;
        end
        if (wr_misc) begin
            misc_clr = misc_clr | reg_req.wdata[pkei_pkg::MISC_BITS-1:0];
        end
    end

    // ==========================================================
    // sense word
    always_comb begin
        key_sense_word = '0;
        key_sense_word[pkei_pkg::BIT_KEY_PUSH] = key_push_sense;
        key_sense_word[pkei_pkg::BIT_HOLD_FIRST +: pkei_pkg::HOLD_STAGES] =
            st.hold_sense;
    end

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.push_prev = key_push_sense;

        // hold counter runs on reference ticks only while pressed
        if (!key_push_sense) begin
            next_st.hold_count = '0;
        end else if (tick && (st.hold_count != pkei_pkg::HOLD_SATURATE)) begin
            next_st.hold_count = st.hold_count + pkei_pkg::HOLD_W'(1);
        end

        // hold sense follows the thresholds and drops with the release
        next_st.hold_sense = hold_now;

        // sticky status: a set in the clearing cycle survives
        next_st.key_status = (st.key_status & ~key_clr) | key_set;
        next_st.misc_status = (st.misc_status & ~misc_clr) | misc_set;

        // mask writes
        if (reg_req.wr && (reg_req.addr == pkei_pkg::ADDR_KEY_MASK)) begin
            next_st.key_mask = reg_req.wdata[pkei_pkg::KEY_BITS-1:0];
        end
        if (reg_req.wr && (reg_req.addr == pkei_pkg::ADDR_MISC_MASK)) begin
            next_st.misc_mask = reg_req.wdata[pkei_pkg::MISC_BITS-1:0];
        end

        // read data, answered one cycle after the strobe
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                pkei_pkg::ADDR_KEY_STATUS: begin
                    next_st.rdata = {2'h0, st.key_status};
                end
                pkei_pkg::ADDR_KEY_MASK: begin
                    next_st.rdata = {2'h0, st.key_mask};
                end
                pkei_pkg::ADDR_KEY_SENSE: begin
                    next_st.rdata = key_sense_word;
                end
                pkei_pkg::ADDR_MISC_STATUS: begin
                    next_st.rdata = {5'h00, st.misc_status};
                end
                pkei_pkg::ADDR_MISC_MASK: begin
                    next_st.rdata = {5'h00, st.misc_mask};
                end
                default: begin
                    next_st.rdata = pkei_pkg::READ_UNMAPPED;
                end
            endcase
        end

        // interrupt from the state that is about to be held
        next_st.irq_n = ~(|(next_st.key_status & ~next_st.key_mask) |
            |(next_st.misc_status & ~next_st.misc_mask));
    end

    // ==========================================================
    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st.key_status <= pkei_pkg::KEY_STATUS_RESET;
            st.key_mask <= pkei_pkg::KEY_MASK_RESET;
            st.misc_status <= pkei_pkg::MISC_STATUS_RESET;
            st.misc_mask <= pkei_pkg::MISC_MASK_RESET;
            st.hold_sense <= '0;
            st.push_prev <= 1'b0;
            st.hold_count <= '0;
            st.rdata <= pkei_pkg::READ_UNMAPPED;
            st.irq_n <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata = st.rdata;
    assign irq_out_n = st.irq_n;

endmodule : pkei_top

/* File: tb/pkei_checker.sv */
// checker for the power key block: sees only the top ports.
// assumes one clock domain and the package register map.
`timescale 1ns/1ps
module pkei_checker #(
    parameter int TICK_CYCLES = pkei_pkg::REF_TICK_CYCLES,
    parameter int DW = pkei_pkg::DEB_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic power_key_n,
    input wire logic [DW-1:0] fall_debounce_ms,
    input wire logic [DW-1:0] rise_debounce_ms,
    input wire pkei_pkg::pkei_misc_ev_t misc_ev,
    input wire pkei_pkg::pkei_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_out_n
);
    // ====
    // shadow masks and key level run lengths
    logic [5:0] km;
    logic [2:0] mm;
    logic [19:0] lo_cnt;
    logic [19:0] hi_cnt;
    logic long_lo;
    logic long_hi;
    assign long_lo = int'(lo_cnt) > (int'(fall_debounce_ms) + 2) * TICK_CYCLES + 4;
    assign long_hi = int'(hi_cnt) > (int'(rise_debounce_ms) + 2) * TICK_CYCLES + 4;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            km <= 6'h3F;
            mm <= 3'h7;
            lo_cnt <= 20'h00000;
            hi_cnt <= 20'h00000;
        end else if (ce) begin
            if (reg_req.wr && reg_req.addr == 8'h25) km <= reg_req.wdata[5:0];
            if (reg_req.wr && reg_req.addr == 8'h29) mm <= reg_req.wdata[2:0];
            lo_cnt <= power_key_n ? 20'h00000 : lo_cnt + {19'h00000, ~&lo_cnt};
            hi_cnt <= power_key_n ? hi_cnt + {19'h00000, ~&hi_cnt} : 20'h00000;
        end
    end
    // ====
    // properties
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence rd_s(logic [7:0] a);
        ce && reg_req.rd && !reg_req.wr && reg_req.addr == a;
    endsequence
    sequence idle_s;
        ce && !reg_req.rd && !reg_req.wr && misc_ev == 3'h0;
    endsequence
    reset_values_a: assert property (
        $fell(rst) |-> irq_out_n && reg_rdata == 8'h00)
        else $error("outputs not at reset values");
    key_mask_rd_a: assert property (
        rd_s(8'h25) |=> reg_rdata == {2'h0, $past(km)})
        else $error("key mask readback wrong");
    misc_mask_rd_a: assert property (
        rd_s(8'h29) |=> reg_rdata == {5'h00, $past(mm)})
        else $error("misc mask readback wrong");
    all_masked_a: assert property (
        $stable(km) && $stable(mm) && km == 6'h3F && mm == 3'h7 |-> irq_out_n)
        else $error("interrupt low with all masked");
    irq_on_wake_a: assert property (
        ce && misc_ev.wake_done && !mm[0] && !reg_req.wr |=> !irq_out_n)
        else $error("unmasked wake did not pull interrupt low");
    wake_set_a: assert property (
        ce && misc_ev.wake_done ##1 idle_s ##1 rd_s(8'h28) |=> reg_rdata[0])
        else $error("wake status not set");
    button_set_a: assert property (
        ce && misc_ev.power_button ##1 idle_s ##1 rd_s(8'h28) |=> reg_rdata[2])
        else $error("button status not set");
    read_clear_a: assert property (
        rd_s(8'h28) ##0 misc_ev == 3'h0 ##1 idle_s ##1 rd_s(8'h28) |=> reg_rdata == 8'h00)
        else $error("read did not clear misc status");
    push_sense_a: assert property (
        rd_s(8'h26) ##0 long_lo |=> reg_rdata[0])
        else $error("push sense low while key held");
    hold_clear_a: assert property (
        rd_s(8'h26) ##0 long_hi |=> reg_rdata == 8'h00)
        else $error("sense not cleared after release");
endmodule : pkei_checker

bind pkei_top pkei_checker #(.TICK_CYCLES(TICK_CYCLES), .DW(DW)) chk_u (
    .mclk(mclk), .rst(rst), .ce(ce), .power_key_n(power_key_n),
    .fall_debounce_ms(fall_debounce_ms), .rise_debounce_ms(rise_debounce_ms),
    .misc_ev(misc_ev), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));

/* File: tb/pkei_key_model.sv */
// push-button model: raw key, low while pressed, optional chatter.
// assumes press changes just after a rising edge.
`timescale 1ns/1ps
module pkei_key_model (
    input wire logic mclk,
    input wire logic press,
    input wire logic chatter,
    output logic power_key_n
);
    logic held = 1'h0;
    logic [2:0] left = 3'h0;
    initial power_key_n = 1'h1;
    always @(posedge mclk) begin
        if (press != held) begin
            held <= press;
            left <= chatter ? 3'h4 : 3'h0;
        end
        // contacts bounce for a few cycles before settling
        if (left != 3'h0) begin
            left <= left - 3'h1;
            power_key_n <= ~power_key_n;
        end else begin
            power_key_n <= ~held;
        end
    end
endmodule : pkei_key_model

/* File: tb/pkei_top_tb.sv */
// bench for the power key block: table of register cases, then press,
// hold, clock-enable and reset cases. assumes a 125 MHz clock.
`timescale 1ns/1ps
module pkei_top_tb;
    localparam int TC = 2;
    localparam int LIMIT = 40000;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] ev;
        logic irq;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdv;
    } pkei_row_t;
    localparam pkei_row_t ROWS [17] = '{
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h24, 8'h00, 8'h00},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h25, 8'h00, 8'h3F},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h29, 8'h00, 8'h07},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h30, 8'h00, 8'h00},
        '{1'h0, 1'h0, 3'h4, 1'h1, 8'h00, 8'h00, 8'h00},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h28, 8'h00, 8'h01},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h28, 8'h00, 8'h00},
        '{1'h1, 1'h0, 3'h0, 1'h1, 8'h29, 8'h06, 8'h00},
        '{1'h0, 1'h0, 3'h4, 1'h0, 8'h00, 8'h00, 8'h00},
        '{1'h1, 1'h0, 3'h0, 1'h1, 8'h28, 8'h01, 8'h00},
        '{1'h0, 1'h0, 3'h2, 1'h1, 8'h00, 8'h00, 8'h00},
        '{1'h0, 1'h0, 3'h1, 1'h1, 8'h00, 8'h00, 8'h00},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h28, 8'h00, 8'h06},
        '{1'h1, 1'h0, 3'h0, 1'h1, 8'h26, 8'hFF, 8'h00},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h26, 8'h00, 8'h00},
        '{1'h1, 1'h0, 3'h0, 1'h1, 8'h25, 8'h3E, 8'h00},
        '{1'h0, 1'h1, 3'h0, 1'h1, 8'h25, 8'h00, 8'h3E}
    };
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic press = 1'h0;
    logic chatter = 1'h0;
    logic [7:0] deb = 8'h03;
    pkei_pkg::pkei_misc_ev_t misc_ev = '0;
    pkei_pkg::pkei_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic irq_out_n;
    logic power_key_n;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #4 mclk = ~mclk;
    pkei_key_model key_u (.mclk(mclk), .press(press), .chatter(chatter),
        .power_key_n(power_key_n));
    pkei_top #(.TICK_CYCLES(TC)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
        .power_key_n(power_key_n), .fall_debounce_ms(deb), .rise_debounce_ms(deb),
        .misc_ev(misc_ev), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end
    task automatic chk_byte(input string nm, input logic [7:0] ex, input logic [7:0] got);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_byte
    task automatic chk_bit(input string nm, input logic ex, input logic got);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", nm, ex, got);
        end
    endtask : chk_bit
    task automatic op(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d, input logic [2:0] e);
        @(posedge mclk);
        reg_req <= '{w, r, a, d};
        misc_ev <= pkei_pkg::pkei_misc_ev_t'(e);
        @(posedge mclk);
        reg_req <= '0;
        misc_ev <= '0;
        @(negedge mclk);
    endtask : op
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
        op(1'h0, 1'h1, a, 8'h00, 3'h0);
        chk_byte("reg_rdata", ex, reg_rdata);
    endtask : rd_chk
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 200 && irq_out_n !== lvl; i++) @(negedge mclk);
        chk_bit("irq_out_n", lvl, irq_out_n);
    endtask : wait_irq
    task automatic do_reset();
        rst <= 1'h1;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
    endtask : do_reset
    initial begin
        do_reset();
        foreach (ROWS[i]) begin
            op(ROWS[i].wr, ROWS[i].rd, ROWS[i].addr, ROWS[i].wdata, ROWS[i].ev);
            if (ROWS[i].rd) chk_byte("reg_rdata", ROWS[i].rdv, reg_rdata);
            chk_bit("irq_out_n", ROWS[i].irq, irq_out_n);
        end
        // press shorter than the debounce time
        @(posedge mclk);
        press <= 1'h1;
        repeat (2) @(posedge mclk);
        press <= 1'h0;
        repeat (20) @(posedge mclk);
        rd_chk(8'h24, 8'h00);
        @(posedge mclk);
        chatter <= 1'h1;
        press <= 1'h1;
        wait_irq(1'h0);
        rd_chk(8'h24, 8'h01);
        rd_chk(8'h26, 8'h01);
        repeat (1500 * TC) @(posedge mclk);
        rd_chk(8'h26, 8'h03);
        chk_bit("irq_out_n", 1'h1, irq_out_n);
        rd_chk(8'h24, 8'h02);
        repeat (6700 * TC) @(posedge mclk);
        rd_chk(8'h26, 8'h3F);
        rd_chk(8'h24, 8'h3C);
        @(posedge mclk);
        press <= 1'h0;
        wait_irq(1'h0);
        rd_chk(8'h26, 8'h00);
        rd_chk(8'h24, 8'h01);
        @(posedge mclk);
        ce <= 1'h0;
        op(1'h0, 1'h0, 8'h00, 8'h00, 3'h4);
        @(posedge mclk);
        ce <= 1'h1;
        rd_chk(8'h28, 8'h00);
        op(1'h0, 1'h0, 8'h00, 8'h00, 3'h4);
        chk_bit("irq_out_n", 1'h0, irq_out_n);
        do_reset();
        chk_bit("irq_out_n", 1'h1, irq_out_n);
        rd_chk(8'h29, 8'h07);
        rd_chk(8'h25, 8'h3F);
        rd_chk(8'h28, 8'h00);
        conclude();
    end
endmodule : pkei_top_tb
